// ==== mos_map.svh ====
// Purpose: Constants for the misaligned operand splitter.
// Assumes: Big-endian byte lanes on a 32-bit data bus.
// Notes:   Size codes follow the bus encoding; longword is zero.
`ifndef MOS_MAP_SVH
`define MOS_MAP_SVH
`define MOS_SIZE_LONG  2'h0
`define MOS_SIZE_BYTE  2'h1
`define MOS_SIZE_WORD  2'h2
`define MOS_LANE0_MSB  31
`define MOS_LANE3_LSB  0
`endif

// ==== mos_pkg.sv ====
// Purpose: Types for the misaligned operand splitter.
// Assumes: Included map header supplies the numbers.
// Notes:   Holds types only.
`include "mos_map.svh"
package mos_pkg;
  typedef logic [1:0] mos_size_t;
  typedef enum logic [2:0] {
    MOS_IDLE = 3'b001,
    MOS_BUS  = 3'b010,
    MOS_DONE = 3'b100
  } mos_state_e;
endpackage : mos_pkg

// ==== mos_lane.sv ====
// Purpose: Lane steering between operand bytes and big-endian bus lanes.
// Assumes: Offset and size describe an aligned bus cycle.
// Notes:   Purely combinational, a helper of the splitter.
`timescale 1ns/10ps
`include "mos_map.svh"
module mos_lane (
  input  wire logic [1:0]  offset,
  input  wire logic [1:0]  size,
  input  wire logic [31:0] bus_in,
  output logic [3:0]       lane_en,
  output logic [31:0]      lane_data
);
  import mos_pkg::*;
  always_comb begin
    lane_en = 4'h0;
    unique case (size)
      `MOS_SIZE_BYTE: lane_en = 4'h8 >> offset;
      `MOS_SIZE_WORD: lane_en = offset[1] ? 4'h3 : 4'hC;
      default:        lane_en = 4'hF;
    endcase
  end
  // Bytes are kept in their own lanes; offset 0 is bits 31 to 24.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_data[31-8*i -: 8] = lane_en[3-i] ? bus_in[31-8*i -: 8] : 8'h00;
    end
  end
endmodule : mos_lane

// ==== mos_splitter.sv ====
// Purpose: Splits misaligned data operands into aligned bus cycles.
// Assumes: Noncacheable accesses on a 32-bit port; one slave acknowledges each cycle.
// Notes:   A new request is taken only while idle.
// Summary of operation
// [R1] Byte operands are always aligned, never split.
// [R2] Word odd, longword non-multiple-of-four is misaligned.
// [R3] Any data address accepted, no misalignment fault.
// [R4] Odd instruction prefetch raises address error.
// [R5] Misaligned operands become aligned cycle sequences.
// [R6] Longword offset 1: first cycle byte at 1.
// [R7] Second cycle word at offset 2.
// [R8] Third cycle byte at 0, then done.
// [R9] Misaligned word takes exactly two byte cycles.
// [R10] Slave serves selected lanes and acknowledges.
// [R11] Size code zero means longword.
// [R12] Offset 0 sits on bits 31 to 24.
`timescale 1ns/10ps
`include "mos_map.svh"
module mos_splitter (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             req_valid,
  input  wire logic             req_fetch,
  input  wire logic             req_write,
  input  wire logic [31:0]      req_addr,
  input  wire mos_pkg::mos_size_t req_size,
  input  wire logic [31:0]      req_wdata,
  output logic                  req_ready,
  output logic                  rsp_valid,
  output logic [31:0]           rsp_rdata,
  output logic                  addr_error,
  output logic                  bus_start,
  output logic [31:0]           bus_addr,
  output logic [1:0]            transfer_size_code,
  output logic                  bus_write,
  output logic [31:0]           bus_wdata,
  input  wire logic             bus_ack,
  input  wire logic [31:0]      bus_rdata
);
  import mos_pkg::*;

  mos_state_e  st_q, st_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d, baddr_q, baddr_d;
  logic [2:0]  left_q, left_d;
  logic        wr_q, wr_d, start_q, start_d, err_q, err_d;
  logic [1:0]  sz_q, sz_d;
  logic [3:0]  lane_en;
  logic [31:0] lane_rd;

  // Bytes of the operand from the current address; the remaining count
  // decides the widest aligned cycle that still fits.
  function automatic logic [1:0] pick_size(input logic [1:0] off, input logic [2:0] n);
    if (off == 2'h0 && n == 3'h4) pick_size = `MOS_SIZE_LONG; // R11
    else if (!off[0] && n >= 3'h2) pick_size = `MOS_SIZE_WORD;
    else pick_size = `MOS_SIZE_BYTE;
  endfunction : pick_size

  function automatic logic [2:0] size_bytes(input logic [1:0] s);
    unique case (s)
      `MOS_SIZE_LONG: size_bytes = 3'h4;
      `MOS_SIZE_WORD: size_bytes = 3'h2;
      default:        size_bytes = 3'h1;
    endcase
  endfunction : size_bytes

  mos_lane u_lane (
    .offset    (baddr_q[1:0]),
    .size      (sz_q),
    .bus_in    (bus_rdata),
    .lane_en   (lane_en),
    .lane_data (lane_rd)
  );

  logic [2:0] req_n;
  logic [2:0] step;
  always_comb begin
    req_n = size_bytes(req_size);
    step = size_bytes(sz_q);
    st_d = st_q;
    wd_d = wd_q;
    rd_d = rd_q;
    baddr_d = baddr_q;
    left_d = left_q;
    wr_d = wr_q;
    sz_d = sz_q;
    start_d = 1'b0;
    err_d = 1'b0;
    unique case (st_q)
      MOS_IDLE: begin
        if (req_valid) begin
          if (req_fetch && req_addr[0]) begin
            err_d = 1'b1; // R4
            st_d = MOS_DONE;
          end else begin
            // No alignment check on data; splitting covers it. R1 R2 R3
            baddr_d = req_addr;
            left_d = req_n;
            wr_d = req_write;
            wd_d = req_wdata;
            rd_d = 32'h0000_0000;
            sz_d = pick_size(req_addr[1:0], req_n); // R5 R6 R9
            start_d = 1'b1;
            st_d = MOS_BUS;
          end
        end
      end
      MOS_BUS: begin
        if (bus_ack) begin // R10
          // Operand byte k lands in result lane (4-n)+k, right-justified. R12
          for (int b = 0; b < 4; b++) begin
            if (lane_en[3-b]) begin
              rd_d[8*(left_q - 3'(b - int'(baddr_q[1:0])) - 3'h1) +: 8] =
                lane_rd[31-8*b -: 8];
            end
          end
          left_d = left_q - step;
          baddr_d = baddr_q + 32'(step);
          if (left_q == step) begin
            st_d = MOS_DONE; // R8
          end else begin
            sz_d = pick_size(2'(baddr_q[1:0] + 2'(step)), left_q - step); // R7
            start_d = 1'b1;
          end
        end
      end
      MOS_DONE: st_d = MOS_IDLE;
      default: st_d = MOS_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q <= MOS_IDLE;
      wd_q <= 32'h0000_0000;
      rd_q <= 32'h0000_0000;
      baddr_q <= 32'h0000_0000;
      left_q <= 3'h0;
      wr_q <= 1'b0;
      sz_q <= `MOS_SIZE_LONG;
      start_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      st_q <= st_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
      baddr_q <= baddr_d;
      left_q <= left_d;
      wr_q <= wr_d;
      sz_q <= sz_d;
      start_q <= start_d;
      err_q <= err_d;
    end
  end

  // Write bytes: operand is right-justified; put each on its big-endian lane. R12
  logic [31:0] wlane;
  always_comb begin
    wlane = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      if (lane_en[3-b]) begin
        wlane[31-8*b -: 8] =
          wd_q[8*(left_q - 3'(b - int'(baddr_q[1:0])) - 3'h1) +: 8];
      end
    end
  end

  assign req_ready = (st_q == MOS_IDLE);
  assign rsp_valid = (st_q == MOS_DONE);
  assign rsp_rdata = rd_q;
  assign addr_error = err_q;
  assign bus_start = start_q;
  assign bus_addr = baddr_q;
  assign transfer_size_code = sz_q;
  assign bus_write = wr_q && (st_q == MOS_BUS);
  assign bus_wdata = wlane;

  // Assertions.
  property p_byte_single;
    @(posedge mclk) disable iff (!resetn)
      (req_valid && req_ready && !req_fetch && req_size == `MOS_SIZE_BYTE)
      |=> transfer_size_code == `MOS_SIZE_BYTE && bus_start;
  endproperty
  a_byte_single: assert property (p_byte_single) else $error("byte not single cycle"); // R1

  property p_fetch_err;
    @(posedge mclk) disable iff (!resetn)
      (req_valid && req_ready && req_fetch && req_addr[0]) |=> addr_error && !bus_start;
  endproperty
  a_fetch_err: assert property (p_fetch_err) else $error("odd fetch no error"); // R4

  property p_no_data_err;
    @(posedge mclk) disable iff (!resetn)
      (req_valid && req_ready && !req_fetch) |=> !addr_error;
  endproperty
  a_no_data_err: assert property (p_no_data_err) else $error("data fault raised"); // R3

  property p_long1;
    @(posedge mclk) disable iff (!resetn)
      (req_valid && req_ready && !req_fetch && req_size == `MOS_SIZE_LONG
       && req_addr[1:0] == 2'h1) |=>
      (transfer_size_code == `MOS_SIZE_BYTE && bus_addr[1:0] == 2'h1);
  endproperty
  a_long1: assert property (p_long1) else $error("first cycle wrong"); // R6

  property p_second;
    @(posedge mclk) disable iff (!resetn)
      (st_q == MOS_BUS && bus_ack && left_q == 3'h4 && baddr_q[1:0] == 2'h1
       && transfer_size_code == `MOS_SIZE_BYTE) |=>
      (bus_start && transfer_size_code == `MOS_SIZE_WORD && bus_addr[1:0] == 2'h2);
  endproperty
  a_second: assert property (p_second) else $error("second cycle wrong"); // R7

  property p_third;
    @(posedge mclk) disable iff (!resetn)
      (st_q == MOS_BUS && bus_ack && left_q == 3'h3 && baddr_q[1:0] == 2'h2)
      |=> (bus_start && transfer_size_code == `MOS_SIZE_BYTE && bus_addr[1:0] == 2'h0);
  endproperty
  a_third: assert property (p_third) else $error("third cycle wrong"); // R8

  property p_done;
    @(posedge mclk) disable iff (!resetn)
      (st_q == MOS_BUS && bus_ack && left_q == 3'h1) |=> (rsp_valid && !bus_start);
  endproperty
  a_done: assert property (p_done) else $error("operand not completed"); // R8

  property p_word_odd;
    @(posedge mclk) disable iff (!resetn)
      (req_valid && req_ready && !req_fetch && req_size == `MOS_SIZE_WORD
       && req_addr[0]) |=> (transfer_size_code == `MOS_SIZE_BYTE && left_q == 3'h2);
  endproperty
  a_word_odd: assert property (p_word_odd) else $error("odd word not split"); // R2 R9

  property p_aligned_long;
    @(posedge mclk) disable iff (!resetn)
      (st_q == MOS_BUS && transfer_size_code == `MOS_SIZE_LONG)
      |-> (bus_addr[1:0] == 2'h0 && lane_en == 4'hF);
  endproperty
  a_aligned_long: assert property (p_aligned_long) else $error("long misaligned"); // R5 R11
endmodule : mos_splitter

// ==== mos_slave.sv ====
// Purpose: Slave model that answers each aligned bus cycle.
// Assumes: Byte at address a holds 8'h10 plus a; sixteen bytes.
// Notes:   Read lanes toggle when not acknowledged, so stale data never matches.
`timescale 1ns/10ps
module mos_slave (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [3:0]  wait_cycles,
  input  wire logic        bus_start,
  input  wire logic [31:0] bus_addr,
  input  wire logic [1:0]  size,
  input  wire logic        bus_write,
  input  wire logic [31:0] bus_wdata,
  output logic             bus_ack,
  output logic [31:0]      bus_rdata
);
  logic [7:0] mem [16];
  logic       busy;
  logic [3:0] cnt;
  int         n;
  int         k;
  initial for (k = 0; k < 16; k++) mem[k] = 8'h10 + 8'(k);
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busy      <= 1'b0;
      cnt       <= 4'h0;
      bus_ack   <= 1'b0;
      bus_rdata <= 32'h0;
    end else begin
      bus_ack   <= 1'b0;
      bus_rdata <= ~bus_rdata;
      if (bus_start) begin
        busy <= 1'b1;
        cnt  <= wait_cycles;
      end else if (busy && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (busy) begin
        busy    <= 1'b0;
        bus_ack <= 1'b1;
        n = (size == 2'h0) ? 4 : (size == 2'h2) ? 2 : 1;
        for (k = 0; k < 4; k++) begin
          if (k >= bus_addr[1:0] && k < bus_addr[1:0] + n) begin
            if (bus_write) mem[{bus_addr[3:2], 2'(k)}] = bus_wdata[31-8*k -: 8];
            bus_rdata[31-8*k -: 8] <= mem[{bus_addr[3:2], 2'(k)}];
          end
        end
      end
    end
  end
endmodule : mos_slave

// ==== misaligned_operand_splitter_tb.sv ====
// Purpose: Self-checking bench for the operand splitter.
// Assumes: One request at a time, issued the cycle after the answer.
// Notes:   Each cycle is logged as size and offset, so the order is checked too.
`timescale 1ns/10ps
`include "mos_map.svh"
module misaligned_operand_splitter_tb;
  logic        mclk, resetn, req_valid, req_fetch, req_write, req_ready, rsp_valid;
  logic        addr_error, bus_start, bus_write, bus_ack;
  logic [31:0] req_addr, req_wdata, rsp_rdata, bus_addr, bus_wdata, bus_rdata;
  logic [1:0]  req_size, transfer_size_code;
  logic [3:0]  wt;
  int          n_mismatch, total_checks, cyc;
  mos_splitter u_dut (.mclk(mclk), .resetn(resetn), .req_valid(req_valid),
    .req_fetch(req_fetch), .req_write(req_write), .req_addr(req_addr), .req_size(req_size),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .addr_error(addr_error), .bus_start(bus_start),
    .bus_addr(bus_addr), .transfer_size_code(transfer_size_code), .bus_write(bus_write),
    .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_rdata(bus_rdata));
  mos_slave u_slave (.mclk(mclk), .resetn(resetn), .wait_cycles(wt), .bus_start(bus_start),
    .bus_addr(bus_addr), .size(transfer_size_code), .bus_write(bus_write),
    .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_rdata(bus_rdata));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  task automatic op(input logic f, w, input logic [31:0] a, input logic [1:0] s,
                    input logic [31:0] wd, ex, input logic er, input logic [11:0] el,
                    input int nc);
    logic [11:0] lg;
    int          t;
    int          c;
    lg = 12'h0;
    c = 0;
    req_valid <= 1'b1;
    req_fetch <= f;
    req_write <= w;
    req_addr  <= a;
    req_size  <= s;
    req_wdata <= wd;
    @(posedge mclk);
    req_valid <= 1'b0;
    for (t = 0; t < 60 && rsp_valid !== 1'b1; t++) begin
      @(negedge mclk);
      if (bus_start === 1'b1) begin
        lg = {lg[7:0], transfer_size_code, bus_addr[1:0]};
        c++;
      end
    end
    total_checks++;
    if (!(rsp_valid === 1'b1 && req_ready === 1'b0 && addr_error === er && lg === el &&
          c == nc && (w || er || rsp_rdata === ex))) begin
      n_mismatch++;
      $display("[ERR] %0t addr %h got cycles %0d log %h data %h", $time, a, c, lg, rsp_rdata);
    end
    @(posedge mclk);
  endtask : op
  task automatic t_bytes;
    for (int i = 0; i < 4; i++) op(0, 0, 32'h8 + i, `MOS_SIZE_BYTE, 0, 32'h18 + i, 0,
                                   {8'h0, 2'h1, 2'(i)}, 1);
  endtask : t_bytes
  task automatic t_long;
    op(0, 0, 32'h1, `MOS_SIZE_LONG, 0, 32'h11121314, 0, 12'h5A4, 3);
    op(0, 0, 32'h4, `MOS_SIZE_LONG, 0, 32'h14151617, 0, 12'h000, 1);
    op(0, 0, 32'h2, `MOS_SIZE_LONG, 0, 32'h12131415, 0, 12'h0A8, 2);
    op(0, 0, 32'h3, `MOS_SIZE_LONG, 0, 32'h13141516, 0, 12'h786, 3);
  endtask : t_long
  task automatic t_word;
    op(0, 0, 32'h3, `MOS_SIZE_WORD, 0, 32'h1314, 0, 12'h074, 2);
    op(0, 0, 32'h1, `MOS_SIZE_WORD, 0, 32'h1112, 0, 12'h056, 2);
    op(0, 0, 32'h6, `MOS_SIZE_WORD, 0, 32'h1617, 0, 12'h00A, 1);
  endtask : t_word
  task automatic t_write;
    wt <= 4'h3;
    op(0, 1, 32'h5, `MOS_SIZE_LONG, 32'hAABBCCDD, 0, 0, 12'h5A4, 3);
    op(0, 0, 32'h5, `MOS_SIZE_LONG, 0, 32'hAABBCCDD, 0, 12'h5A4, 3);
    wt <= 4'h0;
  endtask : t_write
  task automatic t_fetch;
    op(1, 0, 32'h3, `MOS_SIZE_WORD, 0, 0, 1, 12'h000, 0);
    op(1, 0, 32'h2, `MOS_SIZE_WORD, 0, 32'h1213, 0, 12'h00A, 1);
  endtask : t_fetch
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    {resetn, req_valid, req_fetch, req_write, req_addr, req_size, req_wdata} = '0;
    wt = 4'h0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_bytes();
    t_long();
    t_word();
    t_write();
    t_fetch();
    end_of_test();
  end
endmodule : misaligned_operand_splitter_tb
